// ===== atc_regs.svh
// Register offsets, field positions and constants of the trigger control.
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
`define ATC_OFS_CTRL   4'h0
`define ATC_OFS_CORE   4'h4
`define ATC_REF_HI     15
`define ATC_REF_LO     13
`define ATC_SUSP_B     12
`define ATC_IRQEN_B    11
`define ATC_FLAG_B     10
`define ATC_SHR_B      9
`define ATC_SINGLE_B   8
`define ATC_SWL_B      7
`define ATC_SWC_B      6
`define ATC_CH_HI      5
`define ATC_CH_LO      0
`define ATC_C3_HI      7
`define ATC_C3_LO      6
`define ATC_CORE_HI    7
`define ATC_CORE_LO    0
`define ATC_C3_AN3     2'h0
`define ATC_C3_ANALOG_INPUT_FIFTEEN    2'h1
`define ATC_REF_SUPPLY 3'h0
`endif

// ===== atc_pkg.sv
// Types shared by the trigger control modules.
`default_nettype none
package atc_pkg;
  typedef struct packed {
    logic [2:0] ref_sel;
    logic       suspend;
    logic       irq_en;
    logic       shr;
    logic       single;
    logic       swl;
    logic       swc;
    logic [5:0] chnum;
  } atc_ctl_s;
  typedef enum logic {ATC_IDLE, ATC_ACK} atc_bus_e;
  typedef struct packed {
    atc_bus_e    st;
    logic        wait_q;
    logic [31:0] rdata;
  } atc_bus_s;
  typedef struct packed {
    logic [63:0] trig;
    logic        lvl;
  } atc_trig_s;
endpackage
`default_nettype wire

// ===== atc_ctl_if.sv
// Signals between the bus slave, register file and trigger generator.
`timescale 1ns/1ps
`default_nettype none
interface atc_ctl_if;
  logic [3:0]        addr;
  logic [15:0]       wdata;
  logic [1:0]        ben;
  logic              wr_stb;
  logic [15:0]       rd_word;
  atc_pkg::atc_ctl_s ctl;
  modport bus  (output addr, wdata, ben, wr_stb, input rd_word);
  modport regs (input addr, wdata, ben, wr_stb, output rd_word, ctl);
  modport trig (input ctl);
endinterface
`default_nettype wire

// ===== atc_bus.sv
// Avalon-MM slave with a fixed one-cycle waitrequest answer.
`timescale 1ns/1ps
`default_nettype none
module atc_bus (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  atc_ctl_if.bus           c
);
  atc_pkg::atc_bus_s r;
  atc_pkg::atc_bus_s n;
  always_comb begin
    n = r;
    n.wait_q = 1'h1;
    unique case (r.st)
      atc_pkg::ATC_IDLE: begin
        if (avs_read || avs_write) begin
          n.st = atc_pkg::ATC_ACK;
          n.wait_q = 1'h0;
          n.rdata = avs_read ? {16'h0000, c.rd_word} : '0;
        end
      end
      atc_pkg::ATC_ACK: n.st = atc_pkg::ATC_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: atc_pkg::ATC_IDLE, wait_q: 1'h1, rdata: '0};
    end else begin
      r <= n;
    end
  end
  assign c.addr = avs_address;
  assign c.wdata = avs_writedata[15:0];
  assign c.ben = avs_byteenable[1:0];
  assign c.wr_stb = (r.st == atc_pkg::ATC_ACK) && avs_write;
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wait_q;
endmodule
`default_nettype wire

// ===== atc_trig.sv
// Trigger pulse and level generator gated by suspend.
`timescale 1ns/1ps
`default_nettype none
module atc_trig (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [63:0] chan_sel_pulse,
  output logic [63:0]      chan_trig,
  output logic             level_trig,
  atc_ctl_if.trig          c
);
  atc_pkg::atc_trig_s r;
  atc_pkg::atc_trig_s n;
  always_comb begin
    n.trig = '0;
    n.lvl = 1'h0;
    if (!c.ctl.suspend) begin
      if (c.ctl.single) begin
        n.trig[c.ctl.chnum] = 1'h1;
      end
      if (c.ctl.swc) begin
        n.trig = n.trig | chan_sel_pulse;
      end
      n.lvl = c.ctl.swl;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign chan_trig = r.trig;
  assign level_trig = r.lvl;
endmodule
`default_nettype wire

// ===== atc_top.sv
// Converter trigger, suspend and core input control with Avalon-MM registers.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.svh"
module atc_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  core_busy,
  input  wire logic [63:0] chan_sel_pulse,
  output logic [63:0]      chan_trig,
  output logic             level_trig,
  output logic             suspend_irq,
  output logic             suspended_idle_flag,
  output logic             shr_direct_sample,
  output logic [5:0]       shr_sample_channel,
  output logic [2:0]       ref_select,
  output logic [7:0]       core_input_sel,
  output logic             core3_analog_input_fifteen_sel
);

  typedef struct packed {
    atc_pkg::atc_ctl_s ctl;
    logic [7:0]        core_sel;
    logic              idle;
    logic              irq;
    logic              c3_analog_input_fifteen;
  } atc_top_s;

  atc_top_s r;
  atc_top_s n;

  atc_ctl_if c ();

  // Builds the readable image of the control register.
  function automatic logic [15:0] atc_ctl_img(
    input atc_pkg::atc_ctl_s ctl,
    input logic              idle
  );
    logic [15:0] img;
    img = '0;
    img[`ATC_REF_HI:`ATC_REF_LO] = ctl.ref_sel;
    img[`ATC_SUSP_B] = ctl.suspend;
    img[`ATC_IRQEN_B] = ctl.irq_en;
    img[`ATC_FLAG_B] = idle;
    img[`ATC_SHR_B] = ctl.shr;
    img[`ATC_SINGLE_B] = ctl.single;
    img[`ATC_SWL_B] = ctl.swl;
    img[`ATC_SWC_B] = ctl.swc;
    img[`ATC_CH_HI:`ATC_CH_LO] = ctl.chnum;
    return img;
  endfunction

  // Merges enabled write bytes into an old register image.
  function automatic logic [15:0] atc_merge(
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [1:0]  be
  );
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  logic [15:0] ctl_wr;
  logic [15:0] core_wr;

  always_comb begin
    n = r;
    ctl_wr = atc_merge(atc_ctl_img(r.ctl, r.idle), c.wdata, c.ben);
    core_wr = atc_merge({8'h00, r.core_sel}, c.wdata, c.ben);
    // Trigger bits hold for one clock, then clear themselves.
    n.ctl.single = 1'h0;
    n.ctl.swc = 1'h0;
    if (c.wr_stb && c.addr == `ATC_OFS_CTRL) begin
      n.ctl.ref_sel = ctl_wr[`ATC_REF_HI:`ATC_REF_LO];
      n.ctl.suspend = ctl_wr[`ATC_SUSP_B];
      n.ctl.irq_en = ctl_wr[`ATC_IRQEN_B];
      n.ctl.shr = ctl_wr[`ATC_SHR_B];
      n.ctl.single = ctl_wr[`ATC_SINGLE_B];
      n.ctl.swl = ctl_wr[`ATC_SWL_B];
      n.ctl.swc = ctl_wr[`ATC_SWC_B];
      n.ctl.chnum = ctl_wr[`ATC_CH_HI:`ATC_CH_LO];
    end
    if (c.wr_stb && c.addr == `ATC_OFS_CORE) begin
      n.core_sel = core_wr[7:0];
    end
    n.idle = r.ctl.suspend && !(|core_busy);
    n.irq = r.ctl.irq_en && n.idle && !r.idle;
    n.c3_analog_input_fifteen = n.core_sel[`ATC_C3_HI:`ATC_C3_LO] == `ATC_C3_ANALOG_INPUT_FIFTEEN;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    c.rd_word = '0;
    if (c.addr == `ATC_OFS_CTRL) begin
      c.rd_word = atc_ctl_img(r.ctl, r.idle);
    end else if (c.addr == `ATC_OFS_CORE) begin
      c.rd_word = {8'h00, r.core_sel};
    end
  end

  assign c.ctl = r.ctl;

  atc_bus u_bus (
    .clk            (clk),
    .arst_n         (arst_n),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .c              (c.bus)
  );

  atc_trig u_trig (
    .clk           (clk),
    .arst_n        (arst_n),
    .chan_sel_pulse(chan_sel_pulse),
    .chan_trig     (chan_trig),
    .level_trig    (level_trig),
    .c             (c.trig)
  );

  assign suspend_irq = r.irq;
  assign suspended_idle_flag = r.idle;
  assign shr_direct_sample = r.ctl.shr;
  assign shr_sample_channel = r.ctl.chnum;
  assign ref_select = r.ctl.ref_sel;
  assign core_input_sel = r.core_sel;
  assign core3_analog_input_fifteen_sel = r.c3_analog_input_fifteen;

  // Checks of the register and trigger behaviour.
  default clocking atc_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic ctl_wr_hi;
  logic ctl_wr_lo;
  assign ctl_wr_hi = c.wr_stb && c.addr == `ATC_OFS_CTRL && c.ben[1];
  assign ctl_wr_lo = c.wr_stb && c.addr == `ATC_OFS_CTRL && c.ben[0];
  logic core_wr_lo;
  assign core_wr_lo = c.wr_stb && c.addr == `ATC_OFS_CORE && c.ben[0];

  ref_field_a: assert property (
    ctl_wr_hi |=>
      ref_select == $past(avs_writedata[`ATC_REF_HI:`ATC_REF_LO]))
    else $error("Reference field did not take the written code.");

  suspend_block_a: assert property (
    r.ctl.suspend |=> (chan_trig == '0) && !level_trig)
    else $error("A trigger passed while suspended.");

  idle_set_a: assert property (
    r.ctl.suspend && !(|core_busy) |=> suspended_idle_flag)
    else $error("Idle flag missing with suspend and idle cores.");

  idle_busy_a: assert property (
    (|core_busy) || !r.ctl.suspend |=> !suspended_idle_flag)
    else $error("Idle flag set while a core is busy.");

  irq_cause_a: assert property (
    suspend_irq |->
      $past(r.ctl.irq_en) && suspended_idle_flag && !$past(r.idle))
    else $error("Interrupt without an enabled idle flag rise.");

  irq_off_a: assert property (
    !r.ctl.irq_en |=> !suspend_irq)
    else $error("Interrupt raised while disabled.");

  shr_hold_a: assert property (
    shr_direct_sample && !ctl_wr_hi |=> shr_direct_sample)
    else $error("Direct sample bit changed without a write.");

  single_issue_a: assert property (
    r.ctl.single && !r.ctl.suspend |=>
      chan_trig[$past(r.ctl.chnum)] ##1 !r.ctl.single || ctl_wr_hi)
    else $error("Single trigger was not issued.");

  single_clear_a: assert property (
    r.ctl.single && !ctl_wr_hi |=> !r.ctl.single)
    else $error("Single trigger bit did not clear itself.");

  level_on_a: assert property (
    r.ctl.swl && !r.ctl.suspend |=> level_trig)
    else $error("Level trigger missing while enabled.");

  level_off_a: assert property (
    !r.ctl.swl |=> !level_trig)
    else $error("Level trigger present while disabled.");

  common_issue_a: assert property (
    r.ctl.swc && !r.ctl.suspend |=>
      (chan_trig & $past(chan_sel_pulse)) == $past(chan_sel_pulse))
    else $error("Common trigger missed a selecting channel.");

  common_clear_a: assert property (
    r.ctl.swc && !ctl_wr_lo |=> !r.ctl.swc)
    else $error("Common trigger bit did not clear itself.");

  chnum_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == `ATC_OFS_CTRL
      && !$past(c.wr_stb) |->
      avs_readdata[`ATC_CH_HI:`ATC_CH_LO] == shr_sample_channel)
    else $error("Channel number read back wrong.");

  core_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == `ATC_OFS_CORE
      && !$past(c.wr_stb) |->
      avs_readdata[31:8] == '0 && avs_readdata[7:0] == core_input_sel)
    else $error("Core input register read back wrong.");

  core3_route_a: assert property (
    core3_analog_input_fifteen_sel == (core_input_sel[`ATC_C3_HI:`ATC_C3_LO]
      == `ATC_C3_ANALOG_INPUT_FIFTEEN))
    else $error("Core three routing disagrees with its field.");

  trig_pulse_a: assert property (
    chan_trig != '0 && !$past(r.ctl.swl) |->
      $past(r.ctl.single) || $past(r.ctl.swc))
    else $error("Channel trigger without a software cause.");

  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle.");

  suspend_field_a: assert property (
    ctl_wr_hi |=> r.ctl.suspend == $past(avs_writedata[`ATC_SUSP_B]))
    else $error("Suspend bit did not take the written value.");

  enable_field_a: assert property (
    ctl_wr_hi |=> r.ctl.irq_en == $past(avs_writedata[`ATC_IRQEN_B]))
    else $error("Interrupt enable did not take the written value.");

  direct_field_a: assert property (
    ctl_wr_hi |=> shr_direct_sample == $past(avs_writedata[`ATC_SHR_B]))
    else $error("Direct sample bit did not take the written value.");

  single_field_a: assert property (
    ctl_wr_hi |=> r.ctl.single == $past(avs_writedata[`ATC_SINGLE_B]))
    else $error("Single trigger bit did not take the written value.");

  level_field_a: assert property (
    ctl_wr_lo |=> r.ctl.swl == $past(avs_writedata[`ATC_SWL_B]))
    else $error("Level trigger bit did not take the written value.");

  common_field_a: assert property (
    ctl_wr_lo |=> r.ctl.swc == $past(avs_writedata[`ATC_SWC_B]))
    else $error("Common trigger bit did not take the written value.");

  chnum_field_a: assert property (
    ctl_wr_lo |=> shr_sample_channel
      == $past(avs_writedata[`ATC_CH_HI:`ATC_CH_LO]))
    else $error("Channel number did not take the written value.");

  core_field_a: assert property (
    core_wr_lo |=> core_input_sel
      == $past(avs_writedata[`ATC_CORE_HI:`ATC_CORE_LO]))
    else $error("Core input fields did not take the written value.");

  ref_hold_a: assert property (
    !ctl_wr_hi |=> $stable(ref_select))
    else $error("Reference field changed without a write.");

  suspend_hold_a: assert property (
    !ctl_wr_hi |=> $stable(r.ctl.suspend))
    else $error("Suspend bit changed without a write.");

  chnum_hold_a: assert property (
    !ctl_wr_lo |=> $stable(shr_sample_channel))
    else $error("Channel number changed without a write.");

  core_hold_a: assert property (
    !core_wr_lo |=> $stable(core_input_sel))
    else $error("Core input fields changed without a write.");

  flag_cause_a: assert property (
    suspended_idle_flag |-> $past(r.ctl.suspend) && $past(core_busy) == '0)
    else $error("Idle flag set without suspend and idle cores.");

  irq_raise_a: assert property (
    r.ctl.irq_en && r.ctl.suspend && !(|core_busy) && !suspended_idle_flag
      |=> suspend_irq)
    else $error("Interrupt missing when the idle flag rose.");

  irq_pulse_a: assert property (
    suspend_irq |=> !suspend_irq)
    else $error("Interrupt stood longer than one cycle.");

  trig_quiet_a: assert property (
    !r.ctl.single && !r.ctl.swc |=> chan_trig == '0)
    else $error("Channel trigger without a pending trigger bit.");

  single_one_a: assert property (
    r.ctl.single && !r.ctl.swc && !r.ctl.suspend |=> $onehot(chan_trig))
    else $error("Single trigger did not hit exactly one channel.");

  common_only_a: assert property (
    r.ctl.swc && !r.ctl.single |=>
      (chan_trig & ~$past(chan_sel_pulse)) == '0)
    else $error("Common trigger hit a channel that does not select it.");

  core3_rsv_a: assert property (
    core_input_sel[`ATC_C3_HI] |-> !core3_analog_input_fifteen_sel)
    else $error("Reserved core three code routed input fifteen.");

  bus_rest_a: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("Wait request dropped without a bus request.");

  rdata_upper_a: assert property (
    avs_readdata[31:16] == '0)
    else $error("Upper read data half is not zero.");

  single_cv: cover property (r.ctl.single && !r.ctl.suspend ##1
    chan_trig != '0);
  common_cv: cover property (r.ctl.swc && chan_sel_pulse != '0);
  level_cv: cover property (level_trig [*3]);
  irq_cv: cover property (suspend_irq);
  busy_cv: cover property (r.ctl.suspend && (|core_busy) ##1
    !(|core_busy) ##1 suspended_idle_flag);

endmodule
`default_nettype wire

// ===== atc_partner.sv
// Model of the converter cores and the trigger source selectors.
`timescale 1ns/1ps
`default_nettype none
module atc_partner (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [63:0] chan_trig,
  input  wire logic [63:0] sel_mask,
  input  wire logic        long_conv,
  output logic [63:0]      chan_sel_pulse,
  output logic [4:0]       core_busy
);
  logic [1:0] cnt_reg [4];

  // Each trigger keeps its dedicated core busy for three cycles.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '{default: 2'h0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cnt_reg[i] != 2'h0) cnt_reg[i] <= cnt_reg[i] - 2'h1;
      end
      for (int c = 0; c < 64; c++) begin
        if (chan_trig[c]) cnt_reg[c % 4] <= 2'h3;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      core_busy[i] = (cnt_reg[i] != 2'h0);
    end
    core_busy[4] = long_conv;
  end

  assign chan_sel_pulse = sel_mask;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the converter trigger control.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    logic [15:0] wr;
    logic [63:0] sel;
    logic [63:0] trig;
    logic        lvl;
    logic [15:0] rd;
  } atc_row_s;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rv;
  logic        avs_waitrequest, level_trig, suspend_irq;
  logic        suspended_idle_flag, shr_direct_sample, core3_analog_input_fifteen_sel;
  logic        long_conv = 1'b0;
  logic [4:0]  core_busy;
  logic [63:0] chan_sel_pulse, chan_trig;
  logic [63:0] sel_mask = 64'h0;
  logic [5:0]  shr_sample_channel;
  logic [2:0]  ref_select;
  logic [7:0]  core_input_sel;
  int          n_fail = 0, cmp_count = 0, cyc = 0, irq_cnt = 0;
  atc_row_s    rows [6];

  atc_top i_dut (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .core_busy, .chan_sel_pulse, .chan_trig, .level_trig, .suspend_irq,
    .suspended_idle_flag, .shr_direct_sample, .shr_sample_channel,
    .ref_select, .core_input_sel, .core3_analog_input_fifteen_sel);
  atc_partner i_cores (.clk, .arst_n, .chan_trig, .sel_mask, .long_conv,
    .chan_sel_pulse, .core_busy);

  always #5 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_cnt <= irq_cnt + int'(suspend_irq === 1'b1);
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                        input string nm);
    bus(1'b0, a, 16'h0);
    chk(nm, rv, {16'h0, e});
  endtask

  initial begin
    rows = '{'{16'h0105, 64'h0, 64'h20, 1'b0, 16'h0005},
             '{16'h013f, 64'h0, 64'h8000_0000_0000_0000, 1'b0, 16'h003f},
             '{16'h0040, 64'h8000_0000_0000_0011,
               64'h8000_0000_0000_0011, 1'b0, 16'h0000},
             '{16'h0080, 64'h0, 64'h0, 1'b1, 16'h0080},
             '{16'h1140, 64'h11, 64'h0, 1'b0, 16'h1400},
             '{16'h0000, 64'h0, 64'h0, 1'b0, 16'h0000}};
    repeat (2) @(posedge clk);
    chk("wait_in_reset", avs_waitrequest, 1'b1);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(4'h0, 16'h0, "ctrl_reset");
    rd_chk(4'h4, 16'h0, "core_reset");
    $display("test reset done");
    foreach (rows[i]) begin
      sel_mask <= rows[i].sel;
      bus(1'b1, 4'h0, rows[i].wr);
      @(posedge clk);
      chk("chan_trig", chan_trig, rows[i].trig);
      chk("level_trig", level_trig, rows[i].lvl);
      @(posedge clk);
      chk("trig_once", chan_trig, 64'h0);
      rd_chk(4'h0, rows[i].rd, "ctrl_read");
      $display("test row %0d done", i);
    end
    chk("ref_select", ref_select, 3'h0);
    chk("irq_disabled", irq_cnt, 0);
    bus(1'b1, 4'h0, 16'h0229);
    repeat (3) @(posedge clk);
    chk("direct_on", {shr_direct_sample, shr_sample_channel}, 7'h69);
    bus(1'b1, 4'h0, 16'h0029);
    @(posedge clk);
    chk("direct_off", shr_direct_sample, 1'b0);
    sel_mask <= 64'h0;
    bus(1'b1, 4'h0, 16'h0129);
    @(posedge clk);
    chk("single_41", chan_trig, 64'h200_0000_0000);
    $display("test direct sample done");
    long_conv <= 1'b1;
    bus(1'b1, 4'h0, 16'h1800);
    rd_chk(4'h0, 16'h1800, "flag_busy");
    bus(1'b1, 4'h0, 16'h1c00);
    rd_chk(4'h0, 16'h1800, "flag_ro");
    long_conv <= 1'b0;
    repeat (4) @(posedge clk);
    chk("flag_idle", suspended_idle_flag, 1'b1);
    chk("irq_once", irq_cnt, 1);
    sel_mask <= 64'h1;
    bus(1'b1, 4'h0, 16'h19c0);
    @(posedge clk);
    chk("suspend_block", chan_trig, 64'h0);
    chk("suspend_level", level_trig, 1'b0);
    bus(1'b1, 4'h0, 16'h0000);
    $display("test suspend done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h4, 16'hff2d | 16'(k << 6));
      @(posedge clk);
      chk("core3_analog_input_fifteen", core3_analog_input_fifteen_sel, k == 1);
      chk("core_sel", core_input_sel, 8'h2d | 8'(k << 6));
      rd_chk(4'h4, 16'h002d | 16'(k << 6), "core_read");
    end
    bus(1'b1, 4'h8, 16'hffff);
    rd_chk(4'h8, 16'h0, "unmapped");
    rd_chk(4'h4, 16'h00ed, "core_kept");
    $display("test core select done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("core_sel_rst", core_input_sel, 8'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(4'h4, 16'h0, "core_rst_read");
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
